// *** core/iel_pkg.sv ***
package iel_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_EVENT_FIRST  = 8'h00;
	localparam logic [7:0] ADDR_EVENT_SECOND = 8'h01;
	localparam logic [7:0] ADDR_MASK_FIRST   = 8'h04;
	localparam logic [7:0] ADDR_MASK_SECOND  = 8'h05;

	// ==========================================================
	// Reset values
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'hFF;

	// ==========================================================
	// Bit positions, first event register
	localparam int POS_NEG_OVERCURRENT = 0;
	localparam int POS_POS_OVERCURRENT = 1;
	localparam int POS_SHORT_CIRCUIT   = 2;
	localparam int POS_INPUT_OVERVOLT  = 4;
	localparam int POS_INPUT_UNDERVOLT = 5;
	localparam int POS_LOCKOUT         = 6;

	// Bit positions, second event register
	localparam int POS_POWER_GOOD      = 0;
	localparam int POS_CLOCK_SOURCE    = 1;
	localparam int POS_BUS_ERROR       = 2;
	localparam int POS_THERMAL_PREWARN = 4;
	localparam int POS_THERMAL_WARNING = 5;
	localparam int POS_THERMAL_SHUTDN  = 6;

	// Implemented bits; spare bits 7 and 3 stay zero
	localparam logic [7:0] EVENT_BITS_MASK = 8'h77;

	// ==========================================================
	// Sense vector layout
	localparam int SENSE_COUNT         = 11;
	localparam int SNS_NEG_OVERCURRENT = 0;
	localparam int SNS_POS_OVERCURRENT = 1;
	localparam int SNS_SHORT_CIRCUIT   = 2;
	localparam int SNS_INPUT_OVERVOLT  = 3;
	localparam int SNS_INPUT_UNDERVOLT = 4;
	localparam int SNS_LOCKOUT         = 5;
	localparam int SNS_POWER_GOOD      = 6;
	localparam int SNS_CLOCK_SOURCE    = 7;
	localparam int SNS_THERMAL_PREWARN = 8;
	localparam int SNS_THERMAL_WARNING = 9;
	localparam int SNS_THERMAL_SHUTDN  = 10;

	// ==========================================================
	// Timing: edges after reset release before sensed levels are valid
	localparam logic [1:0] PRIME_CYCLES = 2'h3;

endpackage

// *** core/iel_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module iel_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} iel_sync_state_type;

	iel_sync_state_type state_reg;
	iel_sync_state_type state_next;

	always_comb begin
		state_next        = state_reg;
		state_next.stage1 = async_in;
		state_next.stage2 = state_reg.stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.stage2;

endmodule

`default_nettype wire

// *** core/iel_top.sv ***
// Summary of operation
// R1: Each event bit except bus error (second register bit 2) sets on any rising or falling change of its condition.
// R2: Writing one clears an event bit; writing zero leaves it unchanged.
// R3: First register bit 0 latches negative overcurrent until cleared.
// R4: First register bit 1 latches high-side output overcurrent until cleared.
// R5: First register bit 4 latches input overvoltage condition changes.
// R6: First register bit 5 latches input undervoltage condition changes.
// R7: Second register bit 0 latches power-good condition changes.
// R8: Second register bit 1 latches switching frequency source changes.
// R9: Second register bit 5 latches thermal warning condition changes.
// R10: Robust mode: differing consecutive single-byte writes are discarded, bus error set.
// R11: Mask registers, reset all ones, gate each latched event onto interrupt.
// R12: Event register spare bits 7 and 3 read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none

module iel_top (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// Real-time conditions from the analog side
	input  wire logic       neg_overcurrent_sense,
	input  wire logic       pos_overcurrent_sense,
	input  wire logic       short_circuit_sense,
	input  wire logic       input_overvolt_sense,
	input  wire logic       input_undervolt_sense,
	input  wire logic       lockout_sense,
	input  wire logic       power_good_sense,
	input  wire logic       clock_source_sense,
	input  wire logic       thermal_prewarn_sense,
	input  wire logic       thermal_warning_sense,
	input  wire logic       thermal_shutdown_sense,
	// Configuration
	input  wire logic       double_write_check_enable,
	// Register write port from the serial engine
	input  wire logic       wr_en,
	input  wire logic       wr_single,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// Register read port
	input  wire logic       rd_en,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data,
	// Confirmed writes for registers held elsewhere
	output logic            ext_wr_en,
	output logic      [7:0] ext_wr_addr,
	output logic      [7:0] ext_wr_data,
	// Unmasked event pending
	output logic            irq_pending
);

	import iel_pkg::*;

	typedef struct packed {
		logic [7:0]             event_first;
		logic [7:0]             event_second;
		logic [7:0]             mask_first;
		logic [7:0]             mask_second;
		logic [SENSE_COUNT-1:0] prev;
		logic [1:0]             prime;
		logic                   pend_valid;
		logic [7:0]             pend_addr;
		logic [7:0]             pend_data;
		logic [7:0]             rd_data;
		logic                   irq;
		logic                   ext_wr_en;
		logic [7:0]             ext_wr_addr;
		logic [7:0]             ext_wr_data;
	} iel_state_type;

	iel_state_type          state_reg;
	iel_state_type          state_next;
	logic [SENSE_COUNT-1:0] sense_raw;
	logic [SENSE_COUNT-1:0] sense_sync;

	// ==========================================================
	// Input synchronisation
	always_comb begin
		sense_raw                      = '0;
		sense_raw[SNS_NEG_OVERCURRENT] = neg_overcurrent_sense;
		sense_raw[SNS_POS_OVERCURRENT] = pos_overcurrent_sense;
		sense_raw[SNS_SHORT_CIRCUIT]   = short_circuit_sense;
		sense_raw[SNS_INPUT_OVERVOLT]  = input_overvolt_sense;
		sense_raw[SNS_INPUT_UNDERVOLT] = input_undervolt_sense;
		sense_raw[SNS_LOCKOUT]         = lockout_sense;
		sense_raw[SNS_POWER_GOOD]      = power_good_sense;
		sense_raw[SNS_CLOCK_SOURCE]    = clock_source_sense;
		sense_raw[SNS_THERMAL_PREWARN] = thermal_prewarn_sense;
		sense_raw[SNS_THERMAL_WARNING] = thermal_warning_sense;
		sense_raw[SNS_THERMAL_SHUTDN]  = thermal_shutdown_sense;
	end

	iel_sync #(
		.WIDTH (SENSE_COUNT)
	) u_sync (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.async_in (sense_raw),
		.sync_out (sense_sync)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic [SENSE_COUNT-1:0] change;
		logic [7:0]             set_first;
		logic [7:0]             set_second;
		logic [7:0]             clr_first;
		logic [7:0]             clr_second;
		logic                   commit;
		logic                   bus_error;
		logic                   primed;
		change     = '0;
		set_first  = '0;
		set_second = '0;
		clr_first  = '0;
		clr_second = '0;
		commit     = 1'b0;
		bus_error  = 1'b0;
		primed     = (state_reg.prime == PRIME_CYCLES);
		state_next = state_reg;

		// Hold off edge detection until the synchroniser carries real levels
		state_next.prev = sense_sync;
		if (!primed) begin
			state_next.prime = state_reg.prime + 2'h1;
		end
		if (primed) begin
			change = sense_sync ^ state_reg.prev; // [R1]
		end

		set_first[POS_NEG_OVERCURRENT]  = change[SNS_NEG_OVERCURRENT]; // [R3]
		set_first[POS_POS_OVERCURRENT]  = change[SNS_POS_OVERCURRENT]; // [R4]
		set_first[POS_SHORT_CIRCUIT]    = change[SNS_SHORT_CIRCUIT];
		set_first[POS_INPUT_OVERVOLT]   = change[SNS_INPUT_OVERVOLT]; // [R5]
		set_first[POS_INPUT_UNDERVOLT]  = change[SNS_INPUT_UNDERVOLT]; // [R6]
		set_first[POS_LOCKOUT]          = change[SNS_LOCKOUT];
		set_second[POS_POWER_GOOD]      = change[SNS_POWER_GOOD]; // [R7]
		set_second[POS_CLOCK_SOURCE]    = change[SNS_CLOCK_SOURCE]; // [R8]
		set_second[POS_THERMAL_PREWARN] = change[SNS_THERMAL_PREWARN];
		set_second[POS_THERMAL_WARNING] = change[SNS_THERMAL_WARNING]; // [R9]
		set_second[POS_THERMAL_SHUTDN]  = change[SNS_THERMAL_SHUTDN];

		// Write confirmation: a single-byte write waits for its twin
		if (wr_en) begin
			if (double_write_check_enable && wr_single) begin
				if (!state_reg.pend_valid) begin
					state_next.pend_valid = 1'b1; // [R10]
					state_next.pend_addr  = wr_addr;
					state_next.pend_data  = wr_data;
				end else begin
					state_next.pend_valid = 1'b0;
					if (state_reg.pend_addr == wr_addr && state_reg.pend_data == wr_data) begin
						commit = 1'b1;
					end else begin
						bus_error = 1'b1; // [R10]
					end
				end
			end else begin
				state_next.pend_valid = 1'b0;
				commit                = 1'b1;
			end
		end
		set_second[POS_BUS_ERROR] = bus_error; // [R10]

		state_next.ext_wr_en   = 1'b0;
		state_next.ext_wr_addr = wr_addr;
		state_next.ext_wr_data = wr_data;
		if (commit) begin
			case (wr_addr)
				ADDR_EVENT_FIRST: begin
					clr_first = wr_data; // [R2]
				end
				ADDR_EVENT_SECOND: begin
					clr_second = wr_data; // [R2]
				end
				ADDR_MASK_FIRST: begin
					state_next.mask_first = wr_data;
				end
				ADDR_MASK_SECOND: begin
					state_next.mask_second = wr_data;
				end
				default: begin
					state_next.ext_wr_en = 1'b1;
				end
			endcase
		end

		// A new event in the clearing cycle survives the clear
		state_next.event_first  = ((state_reg.event_first & ~clr_first) | set_first)
		                          & EVENT_BITS_MASK; // [R2] [R12]
		state_next.event_second = ((state_reg.event_second & ~clr_second) | set_second)
		                          & EVENT_BITS_MASK; // [R2] [R12]

		// Mask bit one blocks its source
		state_next.irq = |(state_reg.event_first & ~state_reg.mask_first)
		               | |(state_reg.event_second & ~state_reg.mask_second); // [R11]

		if (rd_en) begin
			case (rd_addr)
				ADDR_EVENT_FIRST: begin
					state_next.rd_data = state_reg.event_first; // [R3] [R12]
				end
				ADDR_EVENT_SECOND: begin
					state_next.rd_data = state_reg.event_second; // [R12]
				end
				ADDR_MASK_FIRST: begin
					state_next.rd_data = state_reg.mask_first;
				end
				ADDR_MASK_SECOND: begin
					state_next.rd_data = state_reg.mask_second;
				end
				default: begin
					state_next.rd_data = 8'h00;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg              <= '0;
			state_reg.event_first  <= EVENT_RESET;
			state_reg.event_second <= EVENT_RESET;
			state_reg.mask_first   <= MASK_RESET; // [R11]
			state_reg.mask_second  <= MASK_RESET; // [R11]
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data     = state_reg.rd_data;
	assign ext_wr_en   = state_reg.ext_wr_en;
	assign ext_wr_addr = state_reg.ext_wr_addr;
	assign ext_wr_data = state_reg.ext_wr_data;
	assign irq_pending = state_reg.irq;

endmodule

`default_nettype wire

// *** test/iel_host.sv ***
`timescale 1ns/10ps
`default_nettype none

module iel_host (
	// Clock
	input  wire logic       clk_sys,
	// Register port towards the block
	output logic            wr_en,
	output logic            wr_single,
	output logic      [7:0] wr_addr,
	output logic      [7:0] wr_data,
	output logic            rd_en,
	output logic      [7:0] rd_addr,
	input  wire logic [7:0] rd_data
);
	initial begin
		wr_en = 1'b0;
		wr_single = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_addr = 8'h00;
	end
	// ==========================================================
	// Bus tasks, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
		wr_en <= 1'b1;
		wr_single <= s;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
	endtask
	task automatic idle;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		d = rd_data;
		@(posedge clk_sys);
	endtask
	// Acknowledge captured events
	task automatic clear(input logic [7:0] a, input logic [7:0] bits);
		wr(a, bits, 1'b0);
		idle;
	endtask
endmodule

`default_nettype wire

// *** test/iel_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

module iel_checker (
	// Clock, reset and mode
	input wire logic       clk_sys,
	input wire logic       reset_n,
	input wire logic       double_write_check_enable,
	// Register port
	input wire logic       wr_en,
	input wire logic       wr_single,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic       rd_en,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Results
	input wire logic       ext_wr_en,
	input wire logic [7:0] ext_wr_addr,
	input wire logic [7:0] ext_wr_data,
	input wire logic       irq_pending
);
	// ==========================================================
	// Helper: has any mask write been seen since reset
	logic mask_wr_reg;
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			mask_wr_reg <= 1'b0;
		else if (wr_en && (wr_addr == 8'h04 || wr_addr == 8'h05))
			mask_wr_reg <= 1'b1;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// Properties
	sequence s_two_differ;
		wr_en && wr_single && double_write_check_enable
		##1 wr_en && wr_single && double_write_check_enable
		&& (wr_addr != $past(wr_addr) || wr_data != $past(wr_data));
	endsequence
	property p_reset;
		disable iff (1'b0) !reset_n |=> rd_data == 8'h00 && !ext_wr_en && !irq_pending;
	endproperty
	property p_ext;
		wr_en && !double_write_check_enable && wr_addr > 8'h05
		|=> ext_wr_en && ext_wr_addr == $past(wr_addr) && ext_wr_data == $past(wr_data);
	endproperty
	property p_ext_cause;
		ext_wr_en |-> $past(wr_en);
	endproperty
	property p_unmapped;
		rd_en && rd_addr > 8'h05 |=> rd_data == 8'h00;
	endproperty
	property p_spare;
		rd_en && rd_addr < 8'h02 |=> rd_data[7] == 1'b0 && rd_data[3] == 1'b0;
	endproperty
	property p_hold;
		!rd_en |=> $stable(rd_data);
	endproperty
	property p_robust;
		s_two_differ |=> !ext_wr_en;
	endproperty
	property p_irq_mask;
		irq_pending |-> mask_wr_reg;
	endproperty

	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
	a_ext: assert property (p_ext) else $error("write not forwarded");
	a_ext_cause: assert property (p_ext_cause) else $error("forwarded write without cause");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_spare: assert property (p_spare) else $error("spare bit read as one");
	a_hold: assert property (p_hold) else $error("read data changed without read");
	a_robust: assert property (p_robust) else $error("differing single write executed");
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
endmodule

bind iel_top iel_checker chk_u (.*);

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import iel_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        dwc_en  = 1'b0;
	logic [10:0] sense   = 11'h000;
	logic        wr_en, wr_single, rd_en, ext_wr_en, irq_pending;
	logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, ext_wr_addr, ext_wr_data, got;
	int          fail_count = 0;
	int          total_checks = 0;
	localparam int REG_OF [11] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
	localparam int POS_OF [11] = '{0, 1, 2, 4, 5, 6, 0, 1, 4, 5, 6};

	always #4 clk_sys = ~clk_sys;

	iel_host host_u (.clk_sys(clk_sys), .wr_en(wr_en), .wr_single(wr_single),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data));
	iel_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .neg_overcurrent_sense(sense[0]),
		.pos_overcurrent_sense(sense[1]), .short_circuit_sense(sense[2]),
		.input_overvolt_sense(sense[3]), .input_undervolt_sense(sense[4]),
		.lockout_sense(sense[5]), .power_good_sense(sense[6]), .clock_source_sense(sense[7]),
		.thermal_prewarn_sense(sense[8]), .thermal_warning_sense(sense[9]),
		.thermal_shutdown_sense(sense[10]), .double_write_check_enable(dwc_en),
		.wr_en(wr_en), .wr_single(wr_single), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .ext_wr_en(ext_wr_en),
		.ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data), .irq_pending(irq_pending));

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Idle one cycle while looking at the forwarded write of the last edge
	task automatic probe(input logic en, input logic [7:0] a, input logic [7:0] d);
		fork
			host_u.idle;
			begin
				@(negedge clk_sys);
				check(8'(ext_wr_en), 8'(en));
				check(ext_wr_addr, a);
				check(ext_wr_data, d);
			end
		join
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		host_u.rd(ADDR_EVENT_FIRST, got);
		check(got, 8'h00);
		host_u.rd(ADDR_EVENT_SECOND, got);
		check(got, 8'h00);
		host_u.rd(ADDR_MASK_FIRST, got);
		check(got, 8'hFF);
		host_u.rd(ADDR_MASK_SECOND, got);
		check(got, 8'hFF);
		host_u.rd(8'h0D, got);
		check(got, 8'h00);
	endtask
	task automatic t_edges;
		for (int i = 0; i < 11; i++) begin
			for (int e = 0; e < 2; e++) begin
				sense[i] <= ~sense[i];
				repeat (4) @(posedge clk_sys);
				host_u.wr(8'(REG_OF[i]), 8'h00, 1'b0);
				host_u.rd(8'(REG_OF[i]), got);
				check(got, 8'h01 << POS_OF[i]);
				host_u.clear(8'(REG_OF[i]), 8'hFF);
				host_u.rd(8'(REG_OF[i]), got);
				check(got, 8'h00);
			end
		end
	endtask
	task automatic t_irq;
		host_u.wr(ADDR_MASK_FIRST, 8'hFE, 1'b0);
		host_u.idle;
		sense[0] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check(8'(irq_pending), 8'h01);
		host_u.clear(ADDR_EVENT_FIRST, 8'h01);
		@(posedge clk_sys);
		check(8'(irq_pending), 8'h00);
		host_u.wr(ADDR_MASK_FIRST, 8'hFF, 1'b0);
		host_u.idle;
		sense[0] <= 1'b0;
		repeat (5) @(posedge clk_sys);
		check(8'(irq_pending), 8'h00);
		host_u.clear(ADDR_EVENT_FIRST, 8'h01);
	endtask
	task automatic t_robust;
		host_u.wr(8'h09, 8'h5A, 1'b0);
		probe(1'b1, 8'h09, 8'h5A);
		dwc_en <= 1'b1;
		host_u.wr(8'h09, 8'hAA, 1'b1);
		probe(1'b0, 8'h09, 8'hAA);
		host_u.wr(8'h09, 8'hAA, 1'b1);
		probe(1'b1, 8'h09, 8'hAA);
		host_u.wr(8'h09, 8'h11, 1'b1);
		host_u.wr(8'h09, 8'h22, 1'b1);
		probe(1'b0, 8'h09, 8'h22);
		host_u.rd(ADDR_EVENT_SECOND, got);
		check(got, 8'h04);
		host_u.wr(8'h09, 8'h44, 1'b1);
		host_u.wr(8'h0A, 8'h33, 1'b0);
		probe(1'b1, 8'h0A, 8'h33);
		host_u.wr(8'h09, 8'h44, 1'b1);
		probe(1'b0, 8'h09, 8'h44);
		host_u.clear(ADDR_EVENT_SECOND, 8'h04);
		host_u.rd(ADDR_EVENT_SECOND, got);
		check(got, 8'h00);
		dwc_en <= 1'b0;
	endtask
	// Reset in mid-run with an event, a mask and read data all non-default
	task automatic t_midreset;
		host_u.wr(ADDR_MASK_FIRST, 8'h00, 1'b0);
		host_u.idle;
		sense[0] <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check(8'(irq_pending), 8'h01);
		host_u.rd(ADDR_EVENT_FIRST, got);
		check(got, 8'h01);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		host_u.rd(ADDR_EVENT_FIRST, got);
		check(got, 8'h00);
		host_u.rd(ADDR_MASK_FIRST, got);
		check(got, 8'hFF);
		check(8'(irq_pending), 8'h00);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset;
		t_edges;
		t_irq;
		t_robust;
		t_midreset;
		finish_test;
	end
	initial begin
		#100000;
		fail_count++;
		finish_test;
	end
endmodule

`default_nettype wire
